// ==== pkg/i2c_mem_port_consts.svh ====
// Constants of the two-wire memory port: slave addresses, row layout, timing.
// Assumes a single includer context; guarded against double inclusion.
`ifndef I2C_MEM_PORT_CONSTS_SVH
`define I2C_MEM_PORT_CONSTS_SVH

// ============================================================
// Slave addresses (7-bit form, direction bit removed)
`define AUX_SLAVE_ADDR      7'h50
`define MAIN_SLAVE_DEFAULT  7'h51

// ============================================================
// Memory layout
`define ROW_BYTES           8
`define ROW_OFS_W           3
`define MEM_ADDR_W          8
`define MEM_TOP_ADDR        8'hFF
`define MEM_BOTTOM_ADDR     8'h00

// ============================================================
// Timing
`define CLK_FREQ_MHZ        125
`define NV_PROGRAM_TIME_US  10000
`define NV_CYCLES_W         24

// ============================================================
// Buffering
`define WR_FIFO_DEPTH       16

`endif

// ==== pkg/i2c_mem_port_pkg.sv ====
// Types shared by the two-wire memory port and its write buffer.
// Assumes the constants header is on the include path.
`default_nettype none
`include "i2c_mem_port_consts.svh"

package i2c_mem_port_pkg;

    // ============================================================
    // Write word handed to the memory side
    typedef struct packed {
        logic       region;   // 1 = main memory, 0 = auxiliary memory
        logic [7:0] addr;
        logic [7:0] data;
    } wr_word_t;

    // ============================================================
    // Bus engine states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX     = 3'b011,
        ST_TX_ACK = 3'b100
    } bus_state_t;

    // What the byte being received means
    typedef enum logic [1:0] {
        KIND_SLAVE = 2'b00,
        KIND_MADDR = 2'b01,
        KIND_DATA  = 2'b10
    } byte_kind_t;

endpackage

`default_nettype wire

// ==== rtl/wr_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; in_ready low means the source must hold its word.
`default_nettype none

module wr_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // ============================================================
    // Flags come from the count so full and empty are exact
    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = store[rd_ptr];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    // Storage, written at the write index
    always_ff @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ==== rtl/i2c_mem_port.sv ====
// Two-wire slave port giving a bus master byte access to a memory map.
// Assumes SCL and SDA come from pins; all else runs on CLK.
// RD_DATA must follow RD_ADDR within two cycles.
//
// Notes on behaviour
// [RULE1] Data falling under high clock means start
// [RULE2] Data rising under high clock means stop
// [RULE3] Repeated start restarts, expecting a slave address
// [RULE4] Data sampled on clock rise, changes when low
// [RULE5] Send bits after previous clock falling edge
// [RULE6] Ninth bit is acknowledge, low means accepted
// [RULE7] Bytes travel most significant bit first
// [RULE8] Master not-acknowledge ends read, line released
// [RULE9] First byte: seven address bits, direction
// [RULE10] Answer fixed auxiliary and programmable main address
// [RULE11] Unmatched address: silent until next start
// [RULE12] Main equal to auxiliary: answer as main
// [RULE13] Second write byte loads the address counter
// [RULE14] Write accepts bytes within one eight-byte row
// [RULE15] Write past row end wraps within row
// [RULE16] After page write stop, busy and unacknowledging
// [RULE17] Master polls address or waits programming time
// [RULE18] Programming rewrites page, keeping unwritten bytes
// [RULE19] Shadow enable writes skip nonvolatile programming
// [RULE20] Reads start at current address counter
// [RULE21] Dummy write then repeated start selects address
// [RULE22] Reads cross rows, roll from top to zero
// [RULE23] Counter advances after each byte moved
`default_nettype none
`include "i2c_mem_port_consts.svh"

module i2c_mem_port #(
    parameter int NV_PROGRAM_CYCLES = `NV_PROGRAM_TIME_US * `CLK_FREQ_MHZ,
    parameter int FIFO_DEPTH        = `WR_FIFO_DEPTH
) (
    input  wire logic                  CLK,
    input  wire logic                  NRST,
    input  wire logic                  CE,
    input  wire logic                  SCL,
    input  wire logic                  SDA_IN,
    output logic                       SDA_OUT,
    output logic                       SDA_OE,
    input  wire logic [7:0]            MAIN_ADDR_PROG,
    input  wire logic                  MAIN_ADDR_PROG_EN,
    input  wire logic                  SHADOW_EN,
    output logic [7:0]                 RD_ADDR,
    output logic                       RD_REGION,
    input  wire logic [7:0]            RD_DATA,
    output logic                       WR_VALID,
    output i2c_mem_port_pkg::wr_word_t WR_WORD,
    input  wire logic                  WR_READY,
    output logic                       COMMIT,
    output logic                       COMMIT_REGION,
    output logic [4:0]                 COMMIT_ROW,
    output logic [7:0]                 COMMIT_MASK,
    output logic                       BUSY
);
    import i2c_mem_port_pkg::*;

    localparam logic [`NV_CYCLES_W-1:0] NV_LOAD = `NV_CYCLES_W'(NV_PROGRAM_CYCLES);

    // ============================================================
    // Address decode shared by the match and the region pick
    function automatic logic [6:0] main_addr(input logic       en,
                                             input logic [7:0] prog);
        main_addr = en ? prog[7:1] : `MAIN_SLAVE_DEFAULT;
    endfunction

    // Write counter step: stays inside the row
    function automatic logic [7:0] row_wrap_inc(input logic [7:0] a);
        row_wrap_inc = {a[7:`ROW_OFS_W], a[`ROW_OFS_W-1:0] + 3'd1};
    endfunction

    // ============================================================
    // Pin synchronisers and edge detection
    logic       scl_meta;
    logic       scl_sync;
    logic       scl_prev;
    logic       sda_meta;
    logic       sda_sync;
    logic       sda_prev;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    // Two synchroniser flops and one history flop per pin; logic reads the second and third
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else if (CE) begin
            scl_meta <= SCL;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= SDA_IN;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    assign scl_rise   = scl_sync && !scl_prev;
    assign scl_fall   = !scl_sync && scl_prev;
    assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync; // [RULE1] [RULE3]
    assign stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync; // [RULE2]

    // ============================================================
    // Bus engine state
    bus_state_t  state;
    byte_kind_t  kind;
    logic [3:0]  bit_cnt;
    logic [7:0]  rx_shift;
    logic [7:0]  tx_shift;
    logic        is_read;
    logic        master_ack;
    logic        wrote_any;
    logic [7:0]  page_mask;
    logic        commit_pend;
    logic [`NV_CYCLES_W-1:0] nv_timer;

    // Write buffer hookup
    wr_word_t    push_word;
    logic        push_valid;
    logic        push_ready;
    logic        fifo_out_valid;
    wr_word_t    fifo_out_word;

    // Address decision for the byte just received
    logic [6:0]  main_now;
    logic        hit_main;
    logic        hit_aux;
    logic        byte_done;

    assign main_now  = main_addr(MAIN_ADDR_PROG_EN, MAIN_ADDR_PROG); // [RULE10]
    assign hit_main  = (rx_shift[7:1] == main_now); // [RULE9]
    assign hit_aux   = (rx_shift[7:1] == `AUX_SLAVE_ADDR) && !hit_main; // [RULE12]
    assign byte_done = (state == ST_RX) && scl_fall && (bit_cnt == 4'd8);

    // Data byte offered to the buffer on the fall that closes it
    assign push_valid = byte_done && (kind == KIND_DATA);
    assign push_word  = '{region: RD_REGION, addr: RD_ADDR, data: rx_shift};

    // ============================================================
    // Bit counter and receive shifter step on rising clock; the counter clears on the fall after acknowledge
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            bit_cnt    <= 4'h0;
            rx_shift   <= 8'h00;
            master_ack <= 1'b0;
        end else if (CE) begin
            if (start_seen) begin
                bit_cnt <= 4'h0;
            end else if (scl_rise && (state == ST_RX || state == ST_TX)) begin
                bit_cnt <= bit_cnt + 4'h1;
                if (state == ST_RX) begin
                    rx_shift <= {rx_shift[6:0], sda_sync}; // [RULE4] [RULE7]
                end
            end else if (scl_rise && state == ST_TX_ACK) begin
                master_ack <= !sda_sync; // [RULE6] [RULE8]
            end else if (scl_fall && (state == ST_RX_ACK || state == ST_TX_ACK)) begin
                bit_cnt <= 4'h0;
            end
        end
    end

    // ============================================================
    // Framing: state, byte meaning, data line drive
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state    <= ST_IDLE;
            kind     <= KIND_SLAVE;
            is_read  <= 1'b0;
            tx_shift <= 8'h00;
            SDA_OE   <= 1'b0;
        end else if (CE) begin
            if (start_seen) begin
                // Any start, repeated or not, waits for a slave address
                state  <= ST_RX; // [RULE3]
                kind   <= KIND_SLAVE;
                SDA_OE <= 1'b0;
            end else if (stop_seen) begin
                state  <= ST_IDLE; // [RULE2]
                SDA_OE <= 1'b0;
            end else if (scl_fall) begin
                case (state)
                    ST_RX: begin
                        if (bit_cnt == 4'd8) begin
                            case (kind)
                                KIND_SLAVE: begin
                                    // Busy or foreign address: fall silent
                                    if ((hit_main || hit_aux) && !BUSY) begin // [RULE16] [RULE17]
                                        SDA_OE  <= 1'b1; // [RULE6]
                                        state   <= ST_RX_ACK;
                                        is_read <= rx_shift[0]; // [RULE9]
                                    end else begin
                                        state   <= ST_IDLE; // [RULE11]
                                    end
                                end
                                KIND_MADDR: begin
                                    SDA_OE <= 1'b1;
                                    state  <= ST_RX_ACK;
                                end
                                KIND_DATA: begin
                                    // Full buffer refuses the byte with a not-acknowledge
                                    if (push_ready) begin
                                        SDA_OE <= 1'b1;
                                        state  <= ST_RX_ACK;
                                    end else begin
                                        state  <= ST_IDLE;
                                    end
                                end
                                default: begin
                                    state <= ST_IDLE;
                                end
                            endcase
                        end
                    end
                    ST_RX_ACK: begin
                        if (kind == KIND_SLAVE && is_read) begin
                            // First read byte comes from the counter as it stands
                            tx_shift <= RD_DATA; // [RULE20]
                            SDA_OE   <= !RD_DATA[7]; // [RULE5] [RULE7]
                            state    <= ST_TX;
                        end else begin
                            SDA_OE <= 1'b0;
                            state  <= ST_RX;
                            if (kind == KIND_SLAVE) begin
                                kind <= KIND_MADDR; // [RULE13]
                            end else begin
                                kind <= KIND_DATA;
                            end
                        end
                    end
                    ST_TX: begin
                        if (bit_cnt == 4'd8) begin
                            SDA_OE <= 1'b0; // Master owns the ninth bit
                            state  <= ST_TX_ACK;
                        end else begin
                            tx_shift <= {tx_shift[6:0], 1'b0};
                            SDA_OE   <= !tx_shift[6]; // [RULE5] [RULE7]
                        end
                    end
                    ST_TX_ACK: begin
                        if (master_ack) begin
                            tx_shift <= RD_DATA;
                            SDA_OE   <= !RD_DATA[7]; // [RULE5]
                            state    <= ST_TX;
                        end else begin
                            SDA_OE <= 1'b0; // [RULE8]
                            state  <= ST_IDLE;
                        end
                    end
                    default: begin
                        SDA_OE <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Address counter and selected memory region
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RD_ADDR   <= `MEM_BOTTOM_ADDR;
            RD_REGION <= 1'b1;
        end else if (CE) begin
            if (byte_done && kind == KIND_SLAVE && (hit_main || hit_aux) && !BUSY) begin
                RD_REGION <= hit_main; // [RULE12]
            end else if (byte_done && kind == KIND_MADDR) begin
                RD_ADDR <= rx_shift; // [RULE13] [RULE21]
            end else if (byte_done && kind == KIND_DATA && push_ready) begin
                RD_ADDR <= row_wrap_inc(RD_ADDR); // [RULE14] [RULE15] [RULE23]
            end else if (scl_fall && state == ST_TX && bit_cnt == 4'd8) begin
                // Plain 8-bit increment: FFh rolls to 00h, rows are crossed
                RD_ADDR <= RD_ADDR + 8'h01; // [RULE22] [RULE23]
            end
        end
    end

    // ============================================================
    // Page bookkeeping: bytes of the row written
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wrote_any     <= 1'b0;
            page_mask     <= 8'h00;
            commit_pend   <= 1'b0;
            COMMIT_ROW    <= 5'h00;
            COMMIT_REGION <= 1'b0;
        end else if (CE) begin
            if (byte_done && kind == KIND_DATA && push_ready) begin
                wrote_any                          <= 1'b1;
                page_mask[RD_ADDR[`ROW_OFS_W-1:0]] <= 1'b1; // [RULE18]
                COMMIT_ROW                         <= RD_ADDR[7:`ROW_OFS_W];
                COMMIT_REGION                      <= RD_REGION;
            end else if (stop_seen && wrote_any) begin
                wrote_any   <= 1'b0;
                // Shadowed writes stay volatile and never program
                commit_pend <= !SHADOW_EN; // [RULE19]
                if (SHADOW_EN) begin
                    page_mask <= 8'h00;
                end
            end else if (commit_pend && !fifo_out_valid) begin
                // Wait for the buffer to drain so data lands before the commit
                commit_pend <= 1'b0;
                page_mask   <= 8'h00;
            end
        end
    end

    // Commit pulse and mask; unmarked bytes keep old contents
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            COMMIT      <= 1'b0;
            COMMIT_MASK <= 8'h00;
        end else if (CE) begin
            COMMIT <= commit_pend && !fifo_out_valid; // [RULE18]
            if (commit_pend && !fifo_out_valid) begin
                COMMIT_MASK <= page_mask;
            end
        end
    end

    // ============================================================
    // Programming interval: address bytes are refused while it runs
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            nv_timer <= '0;
            BUSY     <= 1'b0;
        end else if (CE) begin
            if (stop_seen && wrote_any && !SHADOW_EN) begin
                nv_timer <= NV_LOAD; // [RULE16]
                BUSY     <= 1'b1;
            end else if (nv_timer != '0) begin
                nv_timer <= nv_timer - 1'b1;
                BUSY     <= (nv_timer != `NV_CYCLES_W'(1));
            end
        end
    end

    // The line is open drain: only a low is ever driven
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SDA_OUT <= 1'b0;
        end else if (CE) begin
            SDA_OUT <= 1'b0;
        end
    end

    // ============================================================
    // Write buffer toward the memory side
    wr_fifo #(
        .WIDTH ($bits(wr_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (CLK),
        .nrst      (NRST),
        .ce        (CE),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (fifo_out_valid),
        .out_ready (WR_READY),
        .out_data  (fifo_out_word)
    );

    assign WR_VALID = fifo_out_valid;
    assign WR_WORD  = fifo_out_word;

endmodule

`default_nettype wire

// ==== verif/i2c_mem_port_assertions.sv ====
// Checker for the memory port, on its ports only.
// Assumes binding to every port instance.
`default_nettype none
module i2c_mem_port_assertions
    import i2c_mem_port_pkg::*;
#(
    parameter int NV_PROGRAM_CYCLES = 400
) (
    input wire logic     CLK,
    input wire logic     NRST,
    input wire logic     SCL,
    input wire logic     SDA_OUT,
    input wire logic     SDA_OE,
    input wire logic     SHADOW_EN,
    input wire logic     WR_VALID,
    input wire wr_word_t WR_WORD,
    input wire logic     WR_READY,
    input wire logic     COMMIT,
    input wire logic     [7:0] COMMIT_MASK,
    input wire logic     BUSY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    int busy_len;
    // ============================================================
    // Busy interval length
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) busy_len <= 0;
        else busy_len <= BUSY ? busy_len + 1 : 0;
    end
    sequence s_pulse; COMMIT ##1 !COMMIT; endsequence
    sequence s_busy_hold; BUSY [*8]; endsequence
    // ============================================================
    // Checks
    chk_open_drain: assert property (SDA_OUT == 1'b0)
        else $error("data output not low");
    chk_oe_scl_low: assert property ($rose(SDA_OE) |-> !SCL)
        else $error("data driven while clock high");
    chk_commit_pulse: assert property (COMMIT |-> s_pulse)
        else $error("commit too long");
    chk_commit_mask: assert property (COMMIT |-> COMMIT_MASK != 8'h00)
        else $error("commit with empty mask");
    chk_commit_drained: assert property (COMMIT |-> !WR_VALID && !$past(WR_VALID))
        else $error("commit before drain");
    chk_busy_no_shadow: assert property ($rose(BUSY) |-> !SHADOW_EN)
        else $error("busy in shadow mode");
    chk_wr_hold: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_WORD))
        else $error("stalled word dropped");
    chk_busy_steady: assert property ($rose(BUSY) |-> s_busy_hold)
        else $error("busy cut short");
    chk_busy_length: assert property ($fell(BUSY) |->
        busy_len >= NV_PROGRAM_CYCLES - 3 && busy_len <= NV_PROGRAM_CYCLES + 2)
        else $error("busy length wrong");
endmodule
bind i2c_mem_port i2c_mem_port_assertions #(.NV_PROGRAM_CYCLES(NV_PROGRAM_CYCLES)) u_chk (
    .CLK(CLK), .NRST(NRST), .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .SHADOW_EN(SHADOW_EN), .WR_VALID(WR_VALID), .WR_WORD(WR_WORD), .WR_READY(WR_READY),
    .COMMIT(COMMIT), .COMMIT_MASK(COMMIT_MASK), .BUSY(BUSY));
`default_nettype wire

// ==== verif/i2c_master_model.sv ====
// Bus master model: drives SCL and its side of SDA.
// Assumes the bench ANDs all drivers onto one wire.
`default_nettype none
module i2c_master_model (
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Idle: both lines high; clock still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // One 125 ns bit, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        sda = b;
        #31 scl = 1'b1;
        #31 r = sda_line;
        #31 scl = 1'b0;
        #32;
    endtask
    // Start and repeated start share one form
    task automatic start();
        sda = 1'b1;
        #31 scl = 1'b1;
        #31 sda = 1'b0;
        #31 scl = 1'b0;
        #32;
    endtask
    task automatic stop();
        sda = 1'b0;
        #31 scl = 1'b1;
        #31 sda = 1'b1;
        #63;
    endtask
    // Eight bits then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], r);
            rx = {rx[6:0], r};
        end
        bit_x(ack_in, ack_out);
    endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Bench for the memory port with a bus master model.
// Assumes package and design compile first.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_mem_port_pkg::*;
    localparam int NV = 400;
    logic        clk = 1'b0, nrst = 1'b0, rdy = 1'b0, hold = 1'b0, shadow = 1'b0;
    logic        prog_en = 1'b0, sda_oe, wr_valid, commit, busy, a;
    logic [7:0]  prog = 8'hA2, rd_data = 8'h00, rd_addr, cm_mask, cmask, rx, d;
    logic [4:0]  cm_row, crow;
    logic [31:0] seed = 32'h32A6;
    wr_word_t    wr_word;
    wr_word_t    q[$];
    int          miscompares = 0, samples_checked = 0, cycles = 0, commits = 0, c0;
    wire logic   scl, sda;
    wire logic   sda_line = sda & ~sda_oe;
    i2c_mem_port #(.NV_PROGRAM_CYCLES(NV), .FIFO_DEPTH(16)) DUT (
        .CLK(clk), .NRST(nrst), .CE(1'b1), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(),
        .SDA_OE(sda_oe), .MAIN_ADDR_PROG(prog), .MAIN_ADDR_PROG_EN(prog_en),
        .SHADOW_EN(shadow), .RD_ADDR(rd_addr), .RD_REGION(), .RD_DATA(rd_data),
        .WR_VALID(wr_valid), .WR_WORD(wr_word), .WR_READY(rdy), .COMMIT(commit),
        .COMMIT_REGION(), .COMMIT_ROW(crow), .COMMIT_MASK(cmask), .BUSY(busy));
    i2c_master_model bus (.sda_line(sda_line), .scl(scl), .sda(sda));
    // ============================================================
    // Expectation helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] mem_byte(input logic [7:0] ad);
        return ad ^ 8'h5A;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wbyte(input logic [7:0] b);
        bus.xfer(b, 1'b1, rx, a);
    endtask
    task automatic hdr(input logic [7:0] b);
        bus.start();
        wbyte(b);
    endtask
    // Bounded polling: a stuck busy fails
    task automatic poll(input logic [7:0] b);
        for (int n = 0; n < 40; n++) begin
            hdr(b);
            bus.stop();
            if (!a) break;
        end
        check(a, 0);
    endtask
    // ============================================================
    // Clock, stalling memory, monitors, timeout
    always #4 clk = ~clk;
    always @(negedge clk) begin
        seed = xs(seed);
        rdy <= !hold && seed[0];
        rd_data <= mem_byte(rd_addr);
    end
    always @(posedge clk) begin
        cycles++;
        if (wr_valid && rdy) q.push_back(wr_word);
        if (commit) begin
            commits++;
            cm_mask = cmask;
            cm_row = crow;
        end
        if (cycles == 60000) begin
            miscompares++;
            stop_test();
        end
    end
    // ============================================================
    // Scenarios
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        repeat (4) @(negedge clk);
        // Main write, busy refusal, polling
        d = seed[7:0];
        hdr(8'hA2); check(a, 0);
        wbyte(8'h05); check(a, 0);
        wbyte(d); check(a, 0);
        bus.stop();
        hdr(8'hA2); check(a, 1);
        bus.stop();
        check(q.pop_front(), {1'b1, 8'h05, d});
        check({cm_row, cm_mask}, {5'd0, 8'h20});
        poll(8'hA2);
        // Stalled memory: 16 words fill, 17th refused
        d = seed[7:0];
        hold = 1'b1;
        hdr(8'hA0);
        wbyte(8'h0E);
        for (int i = 0; i < 17; i++) begin
            wbyte(8'(d + i)); check(a, i == 16);
        end
        bus.stop();
        hold = 1'b0;
        c0 = commits;
        for (int i = 0; i < 600 && commits == c0; i++) @(posedge clk);
        for (int i = 0; i < 16; i++) check(q[i], {1'b0, 5'd1, 3'(6 + i), 8'(d + i)});
        check({cm_row, cm_mask}, {5'd1, 8'hFF});
        q.delete();
        poll(8'hA0);
        // Dummy write, Sr, reads rolling past top
        hdr(8'hA2);
        wbyte(8'hFE);
        hdr(8'hA3); check(a, 0);
        for (int i = 0; i < 3; i++) begin
            bus.xfer(8'hFF, i == 2, rx, a); check(rx, mem_byte(8'(8'hFE + i)));
        end
        bus.stop();
        check(rd_addr, 8'h01);
        hdr(8'hA3);
        bus.xfer(8'hFF, 1'b1, rx, a); check(rx, mem_byte(8'h01));
        bus.stop();
        // Foreign address stays silent
        hdr(8'h44); check(a, 1);
        wbyte(8'hA2); check(a, 1);
        bus.stop();
        // Main on aux address, shadow write
        @(negedge clk);
        prog = 8'hA0;
        prog_en = 1'b1;
        shadow = 1'b1;
        c0 = commits;
        hdr(8'hA0); check(a, 0);
        wbyte(8'h20);
        wbyte(d);
        bus.stop();
        repeat (40) @(posedge clk);
        check(q.pop_front(), {1'b1, 8'h20, d});
        check(commits, c0);
        check(busy, 0);
        stop_test();
    end
endmodule
`default_nettype wire
